// ---- trigger_frontend_defines.vh ----
// Constants for the counter trigger front end: modes, edge options, sources, event slots, pulse timing.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef TRIGGER_FRONTEND_DEFINES_VH
`define TRIGGER_FRONTEND_DEFINES_VH

// Counter modes
`define MODE_TIMER      3'h0
`define MODE_CAPTURE    3'h2
`define MODE_QUAD       3'h3
`define MODE_PWM        3'h4
`define MODE_PWM_DT     3'h5
`define MODE_PWM_PR     3'h6

// Edge stage options
`define EDGE_RISE       2'h0
`define EDGE_FALL       2'h1
`define EDGE_BOTH       2'h2
`define EDGE_LEVEL      2'h3

// Trigger sources: constants first, then the shared inputs
`define SRC_ZERO        4'h0
`define SRC_ONE         4'h1
`define SRC_TRIG_BASE   4'h2
`define SRC_RESET       4'h0
`define NUM_TRIG        14
`define SRC_W           4

// Event slots inside the per-counter selection fields
`define EV_RELOAD       0
`define EV_START        1
`define EV_STOP         2
`define EV_COUNT        3
`define EV_CAPTURE      4
`define NUM_EV          5

// Output pulse length in system clock cycles
`define PULSE_CYCLES    2'h2

`endif

// ---- event_edge_stage.v ----
// One trigger edge stage: rising, falling, both-edge or level pass-through with a pending event.
// Assumes a synchronised input and a consume pulse once per counter clock period.
`timescale 1ns/1ns
`default_nettype none
`include "trigger_frontend_defines.vh"

module event_edge_stage (
  input  wire       clk,
  input  wire       rst,
  input  wire       sig,
  input  wire       sample_en,
  input  wire [1:0] edge_sel,
  input  wire       consume,
  output wire       evt
);

  reg  prev_r;
  reg  pend_r;
  reg  pend_nxt;
  wire rise;
  wire fall;
  wire base;

  assign rise = sample_en & sig & ~prev_r;
  assign fall = sample_en & ~sig & prev_r;
  assign base = consume ? 1'b0 : pend_r;

  // Newly seen edge wins over the consume of the same cycle
  always @* begin
    case (edge_sel)
      `EDGE_RISE:  pend_nxt = base | rise;          // R15 R17
      `EDGE_FALL:  pend_nxt = base | fall;          // R15 R17
      `EDGE_BOTH:  pend_nxt = base ^ (rise | fall); // R15 R18
      default:     pend_nxt = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      prev_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      if (sample_en) begin
        prev_r <= sig;
      end
      pend_r <= pend_nxt;
    end
  end

  assign evt = (edge_sel == `EDGE_LEVEL) ? sig : pend_r; // R15

endmodule
`default_nettype wire

// ---- counter_trigger_frontend.v ----
// Multi-counter trigger front end: enables, prescalers, trigger selection, edge stages,
// command precedence, software commands and output trigger pulses.
// Assumes clk is the peripheral and system clock; counter clock edges arrive as one-cycle ticks.
//
// Overview of operation
// R1: Up to 32 counters, all 16 or 32 bits wide as one shared parameter.
// R2: Capture mode loads the capture register; other modes compare it with the count.
// R3: Software programs the period with n-1 for an n-cycle count sequence.
// R4: Enable-set bits enable, enable-clear bits disable, other counters untouched.
// R5: Configure before enabling; disabling keeps every configuration value.
// R6: Prescaler divides counter clock by a power of two, 1 to 128.
// R7: No prescaling in quadrature mode or PWM with dead time.
// R8: Counter steps on prescaled edges with active count input, level or edge.
// R9: Quadrature and pseudo-random PWM ignore count input, use undivided counter clock.
// R10: Fourteen shared triggers plus zero and one, five selectable events per counter.
// R11: Reload initialises, starts and emits a wrap event; start emits none.
// R12: Software command strobes act exactly like hardware trigger events.
// R13: Start on a stopped counter resumes from the held count unchanged.
// R14: Stop beats reload, reload beats start; reload or start with stop does nothing.
// R15: Each event has rising, falling, both-edge or level pass-through stage.
// R16: Edge detection on counter clock in quadrature mode, else peripheral clock.
// R17: Single-edge modes merge multiple pending edges into one event.
// R18: Both-edge mode toggles pending event, even counts vanish, odd give one.
// R19: Every trigger input is synchronised to the peripheral clock first.
// R20: At most one event per counter clock period is acted on.
// R21: Output pulse width is timed by the system clock, not the counter clock.
// R22: Each output trigger pulse stays high exactly two system clock cycles.
// R23: After reset counters are disabled and sources select constant zero.
`timescale 1ns/1ns
`default_nettype none
`include "trigger_frontend_defines.vh"

module counter_trigger_frontend #(
  parameter NUM_CNT   = 32,  // R1
  parameter CNT_WIDTH = 16   // R1
) (
  input  wire                          clk,
  input  wire                          rst,
  input  wire [`NUM_TRIG-1:0]          trig_in,
  input  wire [NUM_CNT-1:0]            counter_clk_tick,
  input  wire [NUM_CNT-1:0]            counter_enable_set_reg,
  input  wire [NUM_CNT-1:0]            counter_enable_clear_reg,
  input  wire [3*NUM_CNT-1:0]          mode_sel,
  input  wire [3*NUM_CNT-1:0]          prescale_field,
  input  wire [NUM_CNT-1:0]            count_down,
  input  wire [CNT_WIDTH*NUM_CNT-1:0]  period_limit_reg,
  input  wire [CNT_WIDTH*NUM_CNT-1:0]  compare_value,
  input  wire [20*NUM_CNT-1:0]         trigger_source_select_reg,
  input  wire [10*NUM_CNT-1:0]         trigger_edge_select_reg,
  input  wire [NUM_CNT-1:0]            sw_reload_command,
  input  wire [NUM_CNT-1:0]            sw_stop_command,
  input  wire [NUM_CNT-1:0]            sw_start_command,
  input  wire [NUM_CNT-1:0]            sw_capture_command,
  output wire [NUM_CNT-1:0]            counter_enable_reg,
  output wire [NUM_CNT-1:0]            counter_running,
  output wire [CNT_WIDTH*NUM_CNT-1:0]  current_count_reg,
  output wire [CNT_WIDTH*NUM_CNT-1:0]  compare_capture_reg,
  output wire [NUM_CNT-1:0]            upper_wrap_event,
  output wire [NUM_CNT-1:0]            lower_wrap_event,
  output wire [NUM_CNT-1:0]            match_or_capture_event
);

  // Picks one of the sixteen trigger sources
  function trig_pick;
    input [`SRC_W-1:0]     sel;
    input [`NUM_TRIG-1:0]  trig;
    reg   [`SRC_W-1:0]     idx;
    begin
      idx = sel - `SRC_TRIG_BASE;
      if (sel == `SRC_ZERO) begin
        trig_pick = 1'b0;
      end else if (sel == `SRC_ONE) begin
        trig_pick = 1'b1;
      end else begin
        trig_pick = trig[idx];
      end
    end
  endfunction

  // True on the last tick of a prescale period of 2**ps ticks
  function presc_hit;
    input [7:0] div;
    input [2:0] ps;
    reg   [7:0] mask;
    begin
      mask = (8'h01 << ps) - 8'h01;
      presc_hit = ((div & mask) == mask);
    end
  endfunction

  // Two-cycle output stretcher; a fresh event restarts the window
  function [1:0] pulse_next;
    input       fire;
    input [1:0] cur;
    begin
      if (fire) begin
        pulse_next = `PULSE_CYCLES;
      end else if (cur != 2'h0) begin
        pulse_next = cur - 2'h1;
      end else begin
        pulse_next = 2'h0;
      end
    end
  endfunction

  // Mode clocking options: bit 1 skips the prescaler, bit 0 takes every counter clock edge
  function [1:0] clk_opts;
    input [2:0] m;
    begin
      case (m)
        `MODE_QUAD:   clk_opts = 2'h3;
        `MODE_PWM_DT: clk_opts = 2'h2;
        `MODE_PWM_PR: clk_opts = 2'h1;
        default:      clk_opts = 2'h0;
      endcase
    end
  endfunction

  reg [`NUM_TRIG-1:0] sync1_r;
  reg [`NUM_TRIG-1:0] sync2_r;
  reg [NUM_CNT-1:0]   enable_r;

  // Two-stage synchroniser; only the second stage feeds the selectors
  always @(posedge clk) begin
    if (rst) begin
      sync1_r <= {`NUM_TRIG{1'b0}};
      sync2_r <= {`NUM_TRIG{1'b0}};
    end else begin
      sync1_r <= trig_in;                 // R19
      sync2_r <= sync1_r;                 // R19
    end
  end

  // Set and clear strobes touch only their own bit; set wins a collision
  always @(posedge clk) begin
    if (rst) begin
      enable_r <= {NUM_CNT{1'b0}};        // R23
    end else begin
      enable_r <= (enable_r & ~counter_enable_clear_reg) | counter_enable_set_reg; // R4
    end
  end

  assign counter_enable_reg = enable_r;

  genvar i;
  genvar e;
  generate
    for (i = 0; i < NUM_CNT; i = i + 1) begin : g_cnt
      wire [2:0]            mode;
      wire [2:0]            ps;
      wire [CNT_WIDTH-1:0]  period;
      wire                  tick;
      wire                  is_quad;
      wire                  no_presc;
      wire                  undivided;
      wire [1:0]            opts;
      wire                  is_capt;
      wire                  edge_sample;
      wire [`NUM_EV-1:0]    hw_evt;
      wire [`NUM_EV-1:0]    sw_cmd;
      wire                  presc_edge;
      wire                  step;
      wire                  ev_reload;
      wire                  ev_start;
      wire                  ev_stop;
      wire                  ev_capture;
      reg  [20-1:0]         src_sel_r;
      reg  [`NUM_EV-1:0]    sw_pend_r;
      reg  [7:0]            div_r;
      reg                   run_r;
      reg  [CNT_WIDTH-1:0]  count_r;
      reg  [CNT_WIDTH-1:0]  count_nxt;
      reg  [CNT_WIDTH-1:0]  cc_r;
      reg                   up_wrap;
      reg                   dn_wrap;
      reg                   cc_hit;
      reg  [1:0]            up_pulse_r;
      reg  [1:0]            dn_pulse_r;
      reg  [1:0]            cc_pulse_r;

      assign mode      = mode_sel[3*i +: 3];
      assign ps        = prescale_field[3*i +: 3];
      assign period    = period_limit_reg[CNT_WIDTH*i +: CNT_WIDTH];
      assign tick      = counter_clk_tick[i] & enable_r[i];
      assign opts      = clk_opts(mode);
      assign is_quad   = (mode == `MODE_QUAD);
      assign is_capt   = (mode == `MODE_CAPTURE);
      assign no_presc  = opts[1];                           // R7
      assign undivided = opts[0];                           // R9
      // Quadrature samples triggers on counter clock edges only
      assign edge_sample = is_quad ? counter_clk_tick[i] : 1'b1;          // R16
      assign sw_cmd    = {sw_capture_command[i], 1'b0, sw_stop_command[i],
                          sw_start_command[i], sw_reload_command[i]};

      // Selections are held internally so the reset state is a constant source
      always @(posedge clk) begin
        if (rst) begin
          src_sel_r <= {`NUM_EV{`SRC_RESET}};              // R23
        end else begin
          src_sel_r <= trigger_source_select_reg[20*i +: 20];
        end
      end

      for (e = 0; e < `NUM_EV; e = e + 1) begin : g_ev
        wire ev_sig;

        // Source picked outside the port list so the instance sees a plain net
        assign ev_sig = trig_pick(src_sel_r[`SRC_W*e +: `SRC_W], sync2_r); // R10
        event_edge_stage i_event_edge_stage (
          .clk       (clk),
          .rst       (rst),
          .sig       (ev_sig),
          .sample_en (edge_sample),                                       // R16
          .edge_sel  (trigger_edge_select_reg[10*i + 2*e +: 2]),
          .consume   (tick),                                              // R20
          .evt       (hw_evt[e])
        );
      end

      // Software strobes wait for the next counter clock edge like a trigger would
      // A strobe that meets a tick in its own cycle is served at the following tick
      always @(posedge clk) begin
        if (rst) begin
          sw_pend_r <= {`NUM_EV{1'b0}};
        end else begin
          sw_pend_r <= (tick ? {`NUM_EV{1'b0}} : sw_pend_r) | sw_cmd;     // R12
        end
      end

      assign ev_reload  = hw_evt[`EV_RELOAD]  | sw_pend_r[`EV_RELOAD];
      assign ev_start   = hw_evt[`EV_START]   | sw_pend_r[`EV_START];
      assign ev_stop    = hw_evt[`EV_STOP]    | sw_pend_r[`EV_STOP];
      assign ev_capture = hw_evt[`EV_CAPTURE] | sw_pend_r[`EV_CAPTURE];

      // Prescaler runs on counter clock ticks while the counter runs
      // A reload clears it, so the first prescaled step lands a full period later
      always @(posedge clk) begin
        if (rst) begin
          div_r <= 8'h00;
        end else if (tick & ev_reload & ~ev_stop) begin
          div_r <= 8'h00;
        end else if (tick & run_r) begin
          div_r <= div_r + 8'h01;                                         // R6
        end
      end

      assign presc_edge = no_presc | presc_hit(div_r, ps);                // R6 R7
      // Count event gates the prescaled clock; some modes take every tick
      assign step = undivided ? 1'b1 : (presc_edge & hw_evt[`EV_COUNT]); // R8 R9

      // Next count and event flags for one counter clock edge
      always @* begin
        count_nxt = count_r;
        up_wrap   = 1'b0;
        dn_wrap   = 1'b0;
        cc_hit    = 1'b0;
        if (tick) begin
          if (ev_stop) begin
            count_nxt = count_r;                                          // R14
          end else if (ev_reload) begin
            count_nxt = count_down[i] ? period : {CNT_WIDTH{1'b0}};       // R11
            up_wrap   = ~count_down[i];                                   // R11
            dn_wrap   = count_down[i];                                    // R11
          end else if (run_r & step) begin
            if (count_down[i]) begin
              if (count_r == {CNT_WIDTH{1'b0}}) begin
                count_nxt = period;                                       // R3
                dn_wrap   = 1'b1;
              end else begin
                count_nxt = count_r - {{(CNT_WIDTH-1){1'b0}}, 1'b1};
              end
            end else begin
              if (count_r == period) begin
                count_nxt = {CNT_WIDTH{1'b0}};                            // R3
                up_wrap   = 1'b1;
              end else begin
                count_nxt = count_r + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
              end
            end
          end
          // Match counts only a change into the compare value, never a stop tick
          if (is_capt) begin
            cc_hit = run_r & ev_capture;                                  // R2
          end else begin
            cc_hit = run_r & ~ev_stop & (count_nxt != count_r) & (count_nxt == cc_r); // R2
          end
        end
      end

      // Stop beats reload, reload beats start; start leaves the count alone
      always @(posedge clk) begin
        if (rst) begin
          run_r   <= 1'b0;                                                // R23
          count_r <= {CNT_WIDTH{1'b0}};
        end else if (~enable_r[i]) begin
          run_r   <= 1'b0;                                                // R5
        end else begin
          count_r <= count_nxt;                                           // R13
          if (tick) begin
            if (ev_stop) begin
              run_r <= 1'b0;                                              // R14
            end else if (ev_reload | ev_start) begin
              run_r <= 1'b1;                                              // R11 R13 R14
            end
          end
        end
      end

      // Capture overwrites only in capture mode; elsewhere the compare value is tracked
      always @(posedge clk) begin
        if (rst) begin
          cc_r <= {CNT_WIDTH{1'b0}};
        end else if (is_capt) begin
          if (cc_hit) begin
            cc_r <= count_r;                                              // R2
          end
        end else begin
          cc_r <= compare_value[CNT_WIDTH*i +: CNT_WIDTH];                // R2
        end
      end

      // Pulse stretchers on the system clock; a new event restarts the two cycles
      always @(posedge clk) begin
        if (rst) begin
          up_pulse_r <= 2'h0;
          dn_pulse_r <= 2'h0;
          cc_pulse_r <= 2'h0;
        end else begin
          up_pulse_r <= pulse_next(up_wrap, up_pulse_r);                  // R21 R22
          dn_pulse_r <= pulse_next(dn_wrap, dn_pulse_r);                  // R21 R22
          cc_pulse_r <= pulse_next(cc_hit, cc_pulse_r);                   // R21 R22
        end
      end

      assign counter_running[i]                           = run_r;
      assign current_count_reg[CNT_WIDTH*i +: CNT_WIDTH]   = count_r;
      assign compare_capture_reg[CNT_WIDTH*i +: CNT_WIDTH] = cc_r;
      assign upper_wrap_event[i]                          = |up_pulse_r;
      assign lower_wrap_event[i]                          = |dn_pulse_r;
      assign match_or_capture_event[i]                    = |cc_pulse_r;
    end
  endgenerate

endmodule
`default_nettype wire

// ---- periph_model.sv ----
// Far-side peripheral model: counter clock edges for counter 0, one-cycle ticks on request.
// Assumes the bench pulses req for one cycle and sets gap (0 prompt, larger slow).
`timescale 1ns/1ns
`default_nettype none
module periph_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic [3:0] gap,
  output logic            tick
);
  logic [3:0] left_r;
  logic       busy_r;
  // Ticks stay one cycle wide, as a counter clock edge is
  always @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      tick   <= 1'b0;
      left_r <= 4'h0;
    end else begin
      tick <= 1'b0;
      if (req) begin
        busy_r <= 1'b1;
        left_r <= gap;
      end else if (busy_r) begin
        if (left_r == 4'h0) begin
          tick   <= 1'b1;
          busy_r <= 1'b0;
        end else begin
          left_r <= left_r - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- counter_trigger_frontend_props.sv ----
// Port checker for the trigger front end, watching counter 0.
// Assumes single clock clk with synchronous active-high rst.
`timescale 1ns/1ns
`default_nettype none
module frontend_props #(
  parameter NUM_CNT   = 32,
  parameter CNT_WIDTH = 16
) (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic [NUM_CNT-1:0]           counter_clk_tick,
  input wire logic [NUM_CNT-1:0]           counter_enable_set_reg,
  input wire logic [NUM_CNT-1:0]           counter_enable_clear_reg,
  input wire logic [NUM_CNT-1:0]           counter_enable_reg,
  input wire logic [NUM_CNT-1:0]           counter_running,
  input wire logic [CNT_WIDTH*NUM_CNT-1:0] current_count_reg,
  input wire logic [NUM_CNT-1:0]           upper_wrap_event,
  input wire logic [NUM_CNT-1:0]           match_or_capture_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  set_enables_a: assert property (counter_enable_set_reg[0] |=> counter_enable_reg[0])
    else $error("enable set not taken");
  clear_disables_a: assert property (counter_enable_clear_reg[0] && !counter_enable_set_reg[0]
    |=> !counter_enable_reg[0])
    else $error("enable clear not taken");
  idle_holds_a: assert property (!counter_enable_reg[0]
    |=> !counter_running[0] && $stable(current_count_reg[CNT_WIDTH-1:0]))
    else $error("disabled counter changed");
  tick_only_a: assert property (!counter_clk_tick[0] |=> $stable(current_count_reg[CNT_WIDTH-1:0]))
    else $error("count moved without tick");
  wrap_cause_a: assert property ($rose(upper_wrap_event[0]) |-> $past(counter_clk_tick[0]) && counter_running[0])
    else $error("wrap pulse without tick");
  pulse_width_a: assert property (upper_wrap_event[0]
    |-> $past(counter_clk_tick[0]) || $past(counter_clk_tick[0], 2))
    else $error("wrap pulse too long");
  pulse_min_a: assert property ($rose(match_or_capture_event[0]) |=> match_or_capture_event[0])
    else $error("match pulse too short");
  match_cause_a: assert property ($rose(match_or_capture_event[0]) |-> $past(counter_clk_tick[0]))
    else $error("match pulse without tick");
  reset_clean_a: assert property (disable iff (1'b0) rst
    |=> counter_enable_reg == '0 && counter_running == '0 && upper_wrap_event == '0)
    else $error("outputs not cleared by reset");
endmodule
bind counter_trigger_frontend frontend_props #(.NUM_CNT(NUM_CNT), .CNT_WIDTH(CNT_WIDTH)) i_frontend_props (
  .clk(clk), .rst(rst), .counter_clk_tick(counter_clk_tick),
  .counter_enable_set_reg(counter_enable_set_reg), .counter_enable_clear_reg(counter_enable_clear_reg),
  .counter_enable_reg(counter_enable_reg), .counter_running(counter_running),
  .current_count_reg(current_count_reg), .upper_wrap_event(upper_wrap_event),
  .match_or_capture_event(match_or_capture_event));
`default_nettype wire

// ---- counter_trigger_frontend_tb.sv ----
// Self-checking bench for the trigger front end with two counters.
// Assumes periph_model supplies counter 0 ticks; the bench drives triggers and strobes.
`timescale 1ns/1ns
`default_nettype none
module counter_trigger_frontend_tb;
  logic clk, rst, req, tk;
  logic [3:0] gap;
  logic [13:0] trig;
  logic [1:0] es, ec, cd, rl, sp, st, cp, en, run, up, lo, mc;
  logic [5:0] md, ps;
  logic [31:0] per, cmpv, cnt, cc, up_n, mc_n, u0, m0, cyc, lo_n, l0;
  logic [39:0] src;
  logic [19:0] edg;
  int err_count, checked;
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  periph_model i_periph_model (.clk(clk), .rst(rst), .req(req), .gap(gap), .tick(tk));
  counter_trigger_frontend #(.NUM_CNT(2), .CNT_WIDTH(16)) i_counter_trigger_frontend (
    .clk(clk), .rst(rst), .trig_in(trig), .counter_clk_tick({1'b0, tk}),
    .counter_enable_set_reg(es), .counter_enable_clear_reg(ec), .mode_sel(md),
    .prescale_field(ps), .count_down(cd), .period_limit_reg(per), .compare_value(cmpv),
    .trigger_source_select_reg(src), .trigger_edge_select_reg(edg),
    .sw_reload_command(rl), .sw_stop_command(sp), .sw_start_command(st), .sw_capture_command(cp),
    .counter_enable_reg(en), .counter_running(run), .current_count_reg(cnt),
    .compare_capture_reg(cc), .upper_wrap_event(up), .lower_wrap_event(lo),
    .match_or_capture_event(mc));
  // Pulse-cycle counters give pulse width without racing the edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (up[0]) up_n <= up_n + 1;
    if (mc[0]) mc_n <= mc_n + 1;
    if (lo[0]) lo_n <= lo_n + 1;
    if (cyc == 32'd6000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic enab(input logic [1:0] s, input logic [1:0] c);
    @(posedge clk);
    es <= s;
    ec <= c;
    @(posedge clk);
    es <= 2'h0;
    ec <= 2'h0;
    #1;
  endtask
  // Strobe bits: reload, stop, start, capture for counter 0
  task automatic cmd(input logic [3:0] v);
    @(posedge clk);
    {cp[0], st[0], sp[0], rl[0]} <= v;
    @(posedge clk);
    {cp[0], st[0], sp[0], rl[0]} <= 4'h0;
    u0 = up_n;
    m0 = mc_n;
    l0 = lo_n;
  endtask
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      req <= 1'b1;
      gap <= i[0] ? 4'h5 : 4'h0;
      @(posedge clk);
      req <= 1'b0;
      do @(posedge clk); while (tk !== 1'b1);
      repeat (3) @(posedge clk);
    end
    #1;
  endtask
  task automatic cfg(input logic [2:0] m, input logic [2:0] p, input logic [3:0] cs, input logic [1:0] ce);
    @(posedge clk);
    md[2:0] <= m;
    ps[2:0] <= p;
    src[15:12] <= cs;
    edg[7:6] <= ce;
    repeat (2) @(posedge clk);
  endtask
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clk);
      trig[0] <= ~trig[0];
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic state(input logic [15:0] c, input logic r, input logic [31:0] pulses);
    chk("count", {16'h0, c}, {16'h0, cnt[15:0]});
    chk("running", {31'h0, r}, {31'h0, run[0]});
    chk("upper pulses", pulses, up_n - u0);
  endtask
  initial begin
    {req, gap, trig, es, ec, cd, rl, sp, st, cp, md, ps, cmpv, src, edg} = '0;
    {up_n, mc_n, u0, m0, cyc, lo_n, l0} = '0;
    per = 32'h0005_0005;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("enable", 32'h0, {30'h0, en});
    enab(2'h1, 2'h0);
    chk("enable", 32'h1, {30'h0, en});
    enab(2'h2, 2'h1);
    chk("enable", 32'h2, {30'h0, en});
    enab(2'h1, 2'h0);
    cfg(`MODE_TIMER, 3'h0, `SRC_ONE, `EDGE_LEVEL);
    cmd(4'h1);
    ticks(1);
    state(16'h0, 1'b1, 32'd2);
    ticks(3);
    chk("count", 32'h3, {16'h0, cnt[15:0]});
    u0 = up_n;
    ticks(5);
    state(16'h2, 1'b1, 32'd2);
    cfg(`MODE_TIMER, 3'h0, `SRC_ZERO, `EDGE_LEVEL);
    cmd(4'h2);
    ticks(3);
    state(16'h2, 1'b0, 32'd0);
    cmd(4'h4);
    ticks(1);
    state(16'h2, 1'b1, 32'd0);
    cmd(4'h3);
    ticks(1);
    state(16'h2, 1'b0, 32'd0);
    cmd(4'h5);
    ticks(1);
    state(16'h0, 1'b1, 32'd2);
    cfg(`MODE_TIMER, 3'h1, `SRC_ONE, `EDGE_LEVEL);
    cmd(4'h1);
    ticks(5);
    chk("count", 32'h2, {16'h0, cnt[15:0]});
    cfg(`MODE_QUAD, 3'h1, `SRC_ZERO, `EDGE_LEVEL);
    cmd(4'h1);
    ticks(5);
    chk("count", 32'h4, {16'h0, cnt[15:0]});
    cfg(`MODE_PWM_PR, 3'h0, `SRC_ZERO, `EDGE_LEVEL);
    cmd(4'h1);
    ticks(5);
    chk("count", 32'h4, {16'h0, cnt[15:0]});
    @(posedge clk);
    cd[0] <= 1'b1;
    cmpv[15:0] <= 16'h0003;
    cfg(`MODE_PWM_DT, 3'h1, `SRC_ONE, `EDGE_LEVEL);
    cmd(4'h1);
    ticks(7);
    state(16'h5, 1'b1, 32'd0);
    chk("lower pulses", 32'd4, lo_n - l0);
    chk("match pulses", 32'd2, mc_n - m0);
    @(posedge clk);
    cd[0] <= 1'b0;
    cmpv[15:0] <= 16'h0000;
    cfg(`MODE_TIMER, 3'h0, `SRC_TRIG_BASE, `EDGE_RISE);
    cmd(4'h1);
    ticks(1);
    toggle(4);
    ticks(1);
    chk("count", 32'h1, {16'h0, cnt[15:0]});
    cfg(`MODE_TIMER, 3'h0, `SRC_TRIG_BASE, `EDGE_BOTH);
    toggle(2);
    ticks(1);
    chk("count", 32'h1, {16'h0, cnt[15:0]});
    toggle(3);
    ticks(1);
    chk("count", 32'h2, {16'h0, cnt[15:0]});
    cfg(`MODE_TIMER, 3'h0, `SRC_TRIG_BASE, `EDGE_FALL);
    toggle(1);
    ticks(1);
    chk("count", 32'h3, {16'h0, cnt[15:0]});
    cfg(`MODE_CAPTURE, 3'h0, `SRC_ZERO, `EDGE_LEVEL);
    cmd(4'h8);
    ticks(1);
    chk("capture", 32'h3, {16'h0, cc[15:0]});
    chk("match pulses", 32'd2, mc_n - m0);
    enab(2'h0, 2'h1);
    ticks(2);
    state(16'h3, 1'b0, 32'd0);
    report_and_stop();
  end
endmodule
`default_nettype wire
